// ---- hw/fpsr_regs.sv ----
`timescale 1ns/100ps
module fpsr_regs
	import fpsr_pkg::*;
(
	input wire logic clk,
	input wire logic resetn,
	input wire logic sys_wr,
	input wire logic sys_rd,
	input wire logic [7:0] sys_addr,
	input wire logic [31:0] sys_wdata,
	input wire logic privileged,
	output logic [31:0] sys_rdata,
	output logic sys_err,
	input wire logic scr_wr,
	input wire logic scr_rd,
	input wire logic [31:0] scr_wdata,
	output logic [31:0] scr_rdata,
	input wire logic fp_instr,
	output logic fp_allow,
	output logic no_coprocessor_fault,
	input wire logic cmp_valid,
	input wire logic [1:0] cmp_result,
	input wire logic [7:0] exc_events,
	input wire logic new_context,
	input wire logic [7:0] flag_masks,
	input wire logic masks_present,
	output logic alt_half_precision,
	output logic default_nan_mode,
	output logic flush_denormals,
	output logic [1:0] rounding_select,
	output logic lazy_save_enable,
	output logic auto_save_enable,
	output logic preserve_req,
	output logic fpu_irq
);
	logic [31:0] ctx_addr_q;
	logic [31:0] dflt_q;
	logic [31:0] ctx_ctrl_q;
	logic [31:0] copro_q;
	logic [31:0] scr_q;
	logic [31:0] scr_d;
	logic [31:0] sys_rdata_q;
	logic [31:0] scr_rdata_q;
	logic sys_err_q;
	logic fp_allow_q;
	logic fault_q;
	logic preserve_q;
	logic [31:0] ctrl_out_q;
	fpsr_clr_t clr_mode;
	fpsr_exc_if exc();

	// Encoding of compare result onto NZCV
	function automatic logic [3:0] nzcv_of(input logic [1:0] r);
		case (fpsr_cmp_t'(r))
			FPSR_CMP_EQ: nzcv_of = NZCV_EQ;
			FPSR_CMP_LT: nzcv_of = NZCV_LT;
			FPSR_CMP_GT: nzcv_of = NZCV_GT;
			default: nzcv_of = NZCV_UN;
		endcase
	endfunction

	// Access check of one coprocessor field against privilege
	function automatic logic cp_ok(input logic [1:0] f, input logic priv);
		case (f)
			CP_FULL: cp_ok = 1'b1;
			CP_PRIV: cp_ok = priv;
			default: cp_ok = 1'b0;
		endcase
	endfunction

	assign exc.masks = flag_masks;
	assign exc.has_masks = masks_present;

	fpsr_irq u_irq (
		.clk(clk),
		.resetn(resetn),
		.exc(exc)
	);

	// Save mode picked by the context control enables
	always_comb begin
		if (ctx_ctrl_q[LAZY_SAVE_BIT]) begin
			clr_mode = FPSR_CLR_LAZY;
		end else if (ctx_ctrl_q[AUTO_SAVE_BIT]) begin
			clr_mode = FPSR_CLR_AUTO;
		end else begin
			clr_mode = FPSR_CLR_NONE;
		end
	end

	// Privileged register writes
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			ctx_addr_q <= RST_ZERO;
			dflt_q <= RST_ZERO;
			ctx_ctrl_q <= RST_CTX_CTRL;
			copro_q <= RST_ZERO;
		end else if (sys_wr && privileged) begin
			case (sys_addr)
				OFS_CTX_ADDR: ctx_addr_q <= sys_wdata & CTX_ADDR_MASK;
				OFS_DEFAULT: dflt_q <= sys_wdata & CTRL_MASK;
				OFS_CTX_CTRL: ctx_ctrl_q <= sys_wdata & CTX_CTRL_MASK;
				OFS_COPRO: copro_q <= sys_wdata & COPRO_MASK;
				default: ;
			endcase
		end
	end

	// Register read data and error answer
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			sys_rdata_q <= RST_ZERO;
			sys_err_q <= 1'b0;
		end else begin
			sys_err_q <= (sys_rd || sys_wr) && !privileged;
			if (sys_rd && privileged) begin
				case (sys_addr)
					OFS_CTX_ADDR: sys_rdata_q <= ctx_addr_q;
					OFS_DEFAULT: sys_rdata_q <= dflt_q;
					OFS_CTX_CTRL: sys_rdata_q <= ctx_ctrl_q;
					OFS_COPRO: sys_rdata_q <= copro_q;
					default: sys_rdata_q <= RST_ZERO;
				endcase
			end else begin
				sys_rdata_q <= RST_ZERO;
			end
		end
	end

	// Instruction gating by coprocessor access fields
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			fp_allow_q <= 1'b0;
			fault_q <= 1'b0;
		end else begin
			fp_allow_q <= cp_ok(copro_q[COPRO_TEN_LSB +: 2], privileged)
				&& cp_ok(copro_q[COPRO_ELEVEN_LSB +: 2], privileged);
			fault_q <= fp_instr && !(cp_ok(copro_q[COPRO_TEN_LSB +: 2], privileged)
				&& cp_ok(copro_q[COPRO_ELEVEN_LSB +: 2], privileged));
		end
	end

	// Next status/control value; events win over clears
	always_comb begin
		scr_d = scr_q;
		if (new_context) begin
			scr_d = (scr_q & ~CTRL_MASK) | (dflt_q & CTRL_MASK);
		end
		if (scr_rd && fp_allow_q && clr_mode != FPSR_CLR_NONE) begin
			scr_d = RST_ZERO;
		end
		if (scr_wr && fp_allow_q) begin
			scr_d = scr_wdata & SCR_MASK;
		end
		if (cmp_valid && fp_allow_q) begin
			scr_d[FLAG_LSB +: 4] = nzcv_of(cmp_result);
		end
		scr_d[7:0] = scr_d[7:0] | (exc_events & STICKY_MASK);
	end

	// Status/control register, reached only by transfer ports
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			scr_q <= RST_ZERO;
		end else begin
			scr_q <= scr_d;
		end
	end

	// Status read data captured before any forced clear
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			scr_rdata_q <= RST_ZERO;
			preserve_q <= 1'b0;
		end else begin
			scr_rdata_q <= (scr_rd && fp_allow_q) ? scr_q : RST_ZERO;
			preserve_q <= scr_rd && fp_allow_q && clr_mode == FPSR_CLR_LAZY;
		end
	end

	// Registered control outputs to the datapath
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			ctrl_out_q <= RST_ZERO;
		end else begin
			ctrl_out_q <= scr_q & CTRL_MASK;
		end
	end

	assign exc.sticky = scr_q[7:0];
	assign sys_rdata = sys_rdata_q;
	assign sys_err = sys_err_q;
	assign scr_rdata = scr_rdata_q;
	assign fp_allow = fp_allow_q;
	assign no_coprocessor_fault = fault_q;
	assign alt_half_precision = ctrl_out_q[HALF_ALT_BIT];
	assign default_nan_mode = ctrl_out_q[DFLT_NAN_BIT];
	assign flush_denormals = ctrl_out_q[FLUSH_BIT];
	assign rounding_select = ctrl_out_q[RM_LSB +: 2];
	assign lazy_save_enable = ctx_ctrl_q[LAZY_SAVE_BIT];
	assign auto_save_enable = ctx_ctrl_q[AUTO_SAVE_BIT];
	assign preserve_req = preserve_q;
	assign fpu_irq = exc.irq;

	sequence cmp_seen;
		cmp_valid && fp_allow_q && !exc_events[0];
	endsequence
	sequence eq_seen;
		cmp_seen ##0 cmp_result == 2'h0;
	endsequence

	ctx_low_zero_a: assert property (@(posedge clk) disable iff (!resetn)
		ctx_addr_q[2:0] == 3'h0) else $error("context address low bits set");
	cmp_eq_a: assert property (@(posedge clk) disable iff (!resetn)
		eq_seen |=> scr_q[31:28] == 4'h6) else $error("equal compare flags wrong");
	cmp_lt_a: assert property (@(posedge clk) disable iff (!resetn)
		(cmp_seen ##0 cmp_result == 2'h1) |=> scr_q[31:28] == 4'h8)
		else $error("less compare flags wrong");
	sticky_hold_a: assert property (@(posedge clk) disable iff (!resetn)
		(exc_events[DENORM_BIT]) |=> scr_q[DENORM_BIT]) else $error("sticky not set");
	sticky_keep_a: assert property (@(posedge clk) disable iff (!resetn)
		(scr_q[0] && !scr_wr && !scr_rd) |=> scr_q[0]) else $error("sticky lost");
	dflt_clean_a: assert property (@(posedge clk) disable iff (!resetn)
		(dflt_q & ~CTRL_MASK) == RST_ZERO) else $error("default reserved bits set");
	priv_block_a: assert property (@(posedge clk) disable iff (!resetn)
		(sys_wr && !privileged) |=> $stable(copro_q)) else $error("user wrote access reg");
	rd_clear_a: assert property (@(posedge clk) disable iff (!resetn)
		(scr_rd && fp_allow_q && clr_mode != FPSR_CLR_NONE && !scr_wr && !cmp_valid
		&& exc_events == 8'h00 && !new_context) |=> scr_q == RST_ZERO)
		else $error("read did not clear");
	ctx_load_a: assert property (@(posedge clk) disable iff (!resetn)
		(new_context && !scr_wr && !scr_rd)
		|=> (scr_q & CTRL_MASK) == ($past(dflt_q) & CTRL_MASK))
		else $error("defaults not loaded");
	deny_run_a: assert property (@(posedge clk) disable iff (!resetn)
		(copro_q == RST_ZERO) |=> !fp_allow_q) else $error("unit ran while disabled");
	ctrl_out_a: assert property (@(posedge clk) disable iff (!resetn)
		rounding_select == $past(scr_q[23:22])) else $error("rounding out stale");

	// Access refusal and instruction gating
	sys_err_a: assert property (@(posedge clk) disable iff (!resetn)
		((sys_rd || sys_wr) && !privileged) |=> sys_err)
		else $error("user access not refused");
	fault_deny_a: assert property (@(posedge clk) disable iff (!resetn)
		(fp_instr && copro_q[COPRO_TEN_LSB +: 2] == CP_DENIED) |=> no_coprocessor_fault)
		else $error("denied instruction not faulted");
	scr_block_a: assert property (@(posedge clk) disable iff (!resetn)
		(!fp_allow_q && !new_context && exc_events == 8'h00) |=> $stable(scr_q))
		else $error("status changed while disabled");

	// Remaining compare outcomes and sticky clearing
	cmp_gt_a: assert property (@(posedge clk) disable iff (!resetn)
		(cmp_seen ##0 cmp_result == 2'h2) |=> scr_q[31:28] == 4'h2)
		else $error("greater compare flags wrong");
	cmp_un_a: assert property (@(posedge clk) disable iff (!resetn)
		(cmp_seen ##0 cmp_result == 2'h3) |=> scr_q[31:28] == 4'h3)
		else $error("unordered compare flags wrong");
	sticky_zero_a: assert property (@(posedge clk) disable iff (!resetn)
		(scr_wr && fp_allow_q && !scr_wdata[0] && !exc_events[0]) |=> !scr_q[0])
		else $error("sticky not cleared by write");

	// Control outputs follow the status register one cycle later
	half_fmt_a: assert property (@(posedge clk) disable iff (!resetn)
		alt_half_precision == $past(scr_q[HALF_ALT_BIT]))
		else $error("half format out stale");
	nan_mode_a: assert property (@(posedge clk) disable iff (!resetn)
		default_nan_mode == $past(scr_q[DFLT_NAN_BIT]))
		else $error("nan mode out stale");
	flush_out_a: assert property (@(posedge clk) disable iff (!resetn)
		flush_denormals == $past(scr_q[FLUSH_BIT]))
		else $error("flush out stale");

	// Preservation request under lazy saving, forced clear under automatic saving
	sequence auto_rd;
		scr_rd && fp_allow_q && clr_mode == FPSR_CLR_AUTO && !scr_wr && !cmp_valid
		&& exc_events == 8'h00;
	endsequence
	lazy_preserve_a: assert property (@(posedge clk) disable iff (!resetn)
		(scr_rd && fp_allow_q && ctx_ctrl_q[LAZY_SAVE_BIT]) |=> preserve_req)
		else $error("lazy read did not request preservation");
	auto_clear_a: assert property (@(posedge clk) disable iff (!resetn)
		auto_rd |=> scr_q == RST_ZERO && !preserve_req)
		else $error("automatic read did not clear");
endmodule

// ---- hw/fpsr_pkg.sv ----
package fpsr_pkg;
	// Register offsets on the system register port
	localparam logic [7:0] OFS_CTX_ADDR = 8'h08;
	localparam logic [7:0] OFS_DEFAULT = 8'h0c;
	localparam logic [7:0] OFS_CTX_CTRL = 8'h04;
	localparam logic [7:0] OFS_COPRO = 8'h88;
	// Reset values
	localparam logic [31:0] RST_ZERO = 32'h0000_0000;
	localparam logic [31:0] RST_CTX_CTRL = 32'hc000_0000;
	// Context address keeps bits 31:3
	localparam logic [31:0] CTX_ADDR_MASK = 32'hffff_fff8;
	// Status/control field positions
	localparam int FLAG_LSB = 28;
	localparam int HALF_ALT_BIT = 26;
	localparam int DFLT_NAN_BIT = 25;
	localparam int FLUSH_BIT = 24;
	localparam int RM_LSB = 22;
	localparam int DENORM_BIT = 7;
	localparam int INEXACT_BIT = 4;
	// Writable status/control bits and the control field group
	localparam logic [31:0] SCR_MASK = 32'hf7c0_009f;
	localparam logic [31:0] CTRL_MASK = 32'h07c0_0000;
	localparam logic [7:0] STICKY_MASK = 8'h9f;
	// Context control enables
	localparam int AUTO_SAVE_BIT = 31;
	localparam int LAZY_SAVE_BIT = 30;
	localparam logic [31:0] CTX_CTRL_MASK = 32'hc000_0000;
	// Coprocessor access fields, bits 23:20
	localparam logic [31:0] COPRO_MASK = 32'h00f0_0000;
	localparam int COPRO_TEN_LSB = 20;
	localparam int COPRO_ELEVEN_LSB = 22;
	localparam logic [1:0] CP_DENIED = 2'h0;
	localparam logic [1:0] CP_PRIV = 2'h1;
	localparam logic [1:0] CP_FULL = 2'h3;
	// Comparison flag codes NZCV
	localparam logic [3:0] NZCV_EQ = 4'h6;
	localparam logic [3:0] NZCV_LT = 4'h8;
	localparam logic [3:0] NZCV_GT = 4'h2;
	localparam logic [3:0] NZCV_UN = 4'h3;
	typedef enum logic [1:0] {FPSR_CMP_EQ, FPSR_CMP_LT, FPSR_CMP_GT, FPSR_CMP_UN} fpsr_cmp_t;
	typedef enum {FPSR_CLR_NONE, FPSR_CLR_LAZY, FPSR_CLR_AUTO} fpsr_clr_t;
endpackage

// ---- hw/fpsr_exc_if.sv ----
`timescale 1ns/100ps
interface fpsr_exc_if;
	// Sticky state and its interrupt masks
	logic [7:0] sticky;
	logic [7:0] masks;
	logic has_masks;
	logic irq;
	modport regs (input sticky, output masks, output has_masks);
	modport irqgen (input sticky, input masks, input has_masks, output irq);
endinterface

// ---- hw/fpsr_irq.sv ----
`timescale 1ns/100ps
module fpsr_irq
	import fpsr_pkg::*;
(
	input wire logic clk,
	input wire logic resetn,
	fpsr_exc_if.irqgen exc
);
	logic irq_q;
	logic [7:0] src;

	// Per-flag masks, or inexact dropped when no masks exist
	always_comb begin
		src = exc.sticky & STICKY_MASK;
		if (exc.has_masks) begin
			src = src & exc.masks;
		end else begin
			src[INEXACT_BIT] = 1'b0;
		end
	end

	// Request level to the interrupt controller
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			irq_q <= 1'b0;
		end else begin
			irq_q <= |src;
		end
	end
	assign exc.irq = irq_q;

	irq_follow_a: assert property (@(posedge clk) disable iff (!resetn)
		exc.irq == $past(|src)) else $error("irq not tracking flags");
	ixc_nomask_a: assert property (@(posedge clk) disable iff (!resetn)
		(!exc.has_masks && exc.sticky == 8'h10) |=> !exc.irq)
		else $error("inexact raised irq without masks");
endmodule

// ---- testbench/fpsr_core_model.sv ----
`timescale 1ns/100ps
// Core pipeline and privileged software facing the register block
module fpsr_core_model
	import fpsr_pkg::*;
(
	input wire logic clk,
	output logic sys_wr,
	output logic sys_rd,
	output logic [7:0] sys_addr,
	output logic [31:0] sys_wdata,
	output logic privileged,
	output logic scr_wr,
	output logic scr_rd,
	output logic [31:0] scr_wdata,
	output logic fp_instr,
	output logic cmp_valid,
	output logic [1:0] cmp_result,
	output logic [7:0] exc_events,
	output logic new_context,
	output logic [7:0] flag_masks,
	output logic masks_present,
	input wire logic [31:0] sys_rdata,
	input wire logic [31:0] scr_rdata
);
	// Idle levels at time zero
	initial begin
		{sys_wr, sys_rd, sys_addr, scr_wr, scr_rd, fp_instr} = '0;
		{cmp_valid, cmp_result, exc_events, new_context} = '0;
		{sys_wdata, scr_wdata} = {32'h5a5a_a5a5, 32'ha5a5_5a5a};
		{privileged, flag_masks, masks_present} = {1'b1, 8'hff, 1'b1};
	end
	// Register access; strobe held through the taking edge
	task automatic sys_acc(input logic w, input logic [7:0] a, input logic [31:0] d,
		input logic p, output logic [31:0] r);
		@(posedge clk);
		#1;
		{privileged, sys_wr, sys_rd, sys_addr, sys_wdata} = {p, w, !w, a, d};
		@(posedge clk);
		#1;
		r = sys_rdata;
		{sys_wr, sys_rd, sys_wdata} = {2'b00, ~d}; // Released data lines toggle
	endtask
	// Status transfer instruction
	task automatic scr_acc(input logic w, input logic [31:0] d, output logic [31:0] r);
		@(posedge clk);
		#1;
		{scr_wr, scr_rd, scr_wdata} = {w, !w, d};
		@(posedge clk);
		#1;
		r = scr_rdata;
		{scr_wr, scr_rd, scr_wdata} = {2'b00, ~d};
	endtask
	// One-cycle datapath pulses after privilege settles
	task automatic fire(input logic p, input logic fi, input logic cv, input logic [1:0] cr,
		input logic [7:0] ev, input logic nc);
		@(posedge clk);
		#1;
		privileged = p;
		@(posedge clk);
		#1;
		{fp_instr, cmp_valid, cmp_result, exc_events, new_context} = {fi, cv, cr, ev, nc};
		@(posedge clk);
		#1;
		{fp_instr, cmp_valid, cmp_result, exc_events, new_context} = '0;
	endtask
	// Enable sequence: set both access fields, then barrier
	task automatic enable_unit;
		logic [31:0] r;
		sys_acc(1'b0, OFS_COPRO, 32'h0, 1'b1, r);
		sys_acc(1'b1, OFS_COPRO, r | 32'h00f0_0000, 1'b1, r);
		repeat (2) @(posedge clk);
		#1;
	endtask
	// Handler clearing flags directly when no context saving
	task automatic clear_flags;
		logic [31:0] r;
		scr_acc(1'b0, 32'h0, r);
		scr_acc(1'b1, r & ~32'h8f, r);
	endtask
endmodule

// ---- testbench/testbench.sv ----
`timescale 1ns/100ps
module testbench;
	import fpsr_pkg::*;
	logic clk = 1'b0;
	logic resetn = 1'b0;
	logic sys_wr, sys_rd, privileged, scr_wr, scr_rd, fp_instr, cmp_valid, new_context;
	logic masks_present, sys_err, fp_allow, no_coprocessor_fault, alt_half_precision;
	logic default_nan_mode, flush_denormals, lazy_save_enable, auto_save_enable;
	logic preserve_req, fpu_irq;
	logic [1:0] cmp_result, rounding_select;
	logic [7:0] sys_addr, exc_events, flag_masks, ev;
	logic [31:0] sys_wdata, scr_wdata, sys_rdata, scr_rdata, r, v;
	int n_errors = 0;
	int checked = 0;
	integer seed = 32'hf871;
	fpsr_regs dut (.*);
	fpsr_core_model core (.*);
	// Clock
	always #25 clk = ~clk;
	// Compare and count
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checked++;
		if (got !== exp) begin
			n_errors++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic give_verdict;
		$display("checks %0d errors %0d", checked, n_errors);
		if (n_errors == 0 && checked > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask
	task automatic step(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask
	// Expected comparison flags
	function automatic logic [3:0] nzcv(input int c);
		case (c)
			0: return 4'b0110;
			1: return 4'b1000;
			2: return 4'b0010;
			default: return 4'b0011;
		endcase
	endfunction
	// Expected fault for an access field and privilege
	function automatic logic fault_exp(input int c, input logic p);
		return (c == 0) || (c == 1 && !p);
	endfunction
	// Watchdog
	initial begin
		#2000000;
		n_errors++;
		give_verdict();
	end
	initial begin
		step(8);
		resetn = 1'b1;
		// Reset values and four unmapped places
		core.sys_acc(0, OFS_CTX_CTRL, 0, 1, r);
		chk(r, 32'hc000_0000);
		for (int i = 0; i < 4; i++) begin
			core.sys_acc(0, 8'h10 + 8'(i * 32), 0, 1, r);
			chk(r, 0);
		end
		chk(fp_allow, 0);
		// Unprivileged write refused
		core.sys_acc(1, OFS_CTX_ADDR, 32'hffff_fff8, 0, r);
		chk(sys_err, 1);
		core.sys_acc(0, OFS_CTX_ADDR, 0, 1, r);
		chk(r, 0);
		core.scr_acc(1, 32'h00c0_0000, r);
		step(2);
		chk(rounding_select, 0);
		// Access field codes against privilege
		for (int c = 0; c < 4; c++) begin
			if (c != 2) for (int p = 0; p < 2; p++) begin
				core.sys_acc(1, OFS_COPRO, 32'({c[1:0], c[1:0]}) << 20, 1, r);
				core.fire(p[0], 1, 0, 0, 0, 0);
				chk(no_coprocessor_fault, fault_exp(c, p[0]));
			end
		end
		core.enable_unit();
		chk(fp_allow, 1);
		core.sys_acc(1, OFS_CTX_CTRL, 0, 1, r);
		step(1);
		chk({lazy_save_enable, auto_save_enable}, 0);
		// Context address and default status, random values
		for (int i = 0; i < 4; i++) begin
			v = $random(seed);
			core.sys_acc(1, OFS_CTX_ADDR, v, 1, r);
			core.sys_acc(0, OFS_CTX_ADDR, 0, 1, r);
			chk(r, v & 32'hffff_fff8);
			v = $random(seed) & 32'h07c0_0000;
			core.sys_acc(1, OFS_DEFAULT, v, 1, r);
			core.sys_acc(0, OFS_DEFAULT, 0, 1, r);
			chk(r, v);
			core.fire(1, 0, 0, 0, 0, 1);
			step(1);
			chk({alt_half_precision, default_nan_mode, flush_denormals, rounding_select},
				v[26:22]);
			core.scr_acc(0, 0, r);
			chk(r[26:22], v[26:22]);
		end
		// Every comparison outcome
		for (int c = 0; c < 4; c++) begin
			core.fire(1, 0, 1, c[1:0], 0, 0);
			core.scr_acc(0, 0, r);
			chk(r[31:28], nzcv(c));
		end
		// Exception flags, masks and interrupt
		for (int i = 0; i < 6; i++) begin
			ev = (i == 0) ? 8'h10 : 8'($random(seed)) & 8'h9f; // Inexact alone, no masks
			core.masks_present = i[0];
			core.flag_masks = i[0] ? 8'($random(seed)) : 8'hff;
			core.fire(1, 0, 0, 0, ev, 0);
			step(1);
			chk(fpu_irq, |(ev & core.flag_masks & (i[0] ? 8'hff : 8'hef)));
			core.scr_acc(0, 0, r);
			chk(r[7:0], ev);
			core.clear_flags();
			step(2);
			chk(fpu_irq, |(ev & core.flag_masks & (i[0] ? 8'h10 : 8'h00)));
			core.scr_acc(0, 0, r);
			chk(r[7:0], ev & 8'h10);
			// Inexact survives the handler mask; wipe it before the next round
			core.scr_acc(1, 0, r);
		end
		// Read-clear under lazy, then automatic saving
		for (int i = 0; i < 2; i++) begin
			core.sys_acc(1, OFS_CTX_CTRL, i ? 32'h8000_0000 : 32'h4000_0000, 1, r);
			core.fire(1, 0, 0, 0, 8'h01, 0);
			core.scr_acc(0, 0, r);
			chk(r[0], 1);
			chk(preserve_req, i == 0);
			core.scr_acc(0, 0, r);
			chk(r, 0);
		end
		give_verdict();
	end
endmodule
